// ===== verilog/scfg_bank.sv
/*
 Serial configuration register bank with its four-wire serial slave.
 Assumes host frames: chip select low, 16-bit header (read flag then
 15-bit address), then data bytes, clock idle low, MSB first.
*/
// Operation
// - Writing 1 to the reset trigger resets every register, this one included.
// - The reset trigger clears itself and always reads 0.
// - Without hold, direction 0 steps the address down and 1 steps it up.
// - The output pin flag reads 1 always; reads go out only on the data out pin.
// - Mode 0 is normal operation and mode 3 powers the whole device down.
// - A read-only 16-bit maker code sits at offset 0xc and ignores writes.
// - With hold set the address stays fixed for the whole stream.
// - The interface configuration register reads 0x30 after reset.
`timescale 1ns/1ps
module scfg_bank
	import scfg_pkg::*;
#(
	// Arbitrary neutral value
	parameter logic [15:0] MAKER_ID = 16'h5a3c
) (
	input  wire logic  sys_clk,
	input  wire logic  nrst,
	input  wire logic  spi_sclk,
	input  wire logic  spi_cs_n,
	input  wire logic  spi_sdi,
	output logic       spi_sdo,
	output logic       chip_reset,
	output logic [1:0] power_mode,
	output logic       full_power_down,
	output logic       addr_ascend,
	output logic       addr_hold
);
	// =====================================================
	// Pin synchronisers
	logic sclk_s;
	logic cs_n_s;
	logic sdi_s;
	logic cs_act;

	scfg_sync #(.INIT(1'b0)) u_sync_sclk (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.pin     (spi_sclk),
		.sync    (sclk_s)
	);
	scfg_sync #(.INIT(1'b1)) u_sync_cs (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.pin     (spi_cs_n),
		.sync    (cs_n_s)
	);
	scfg_sync #(.INIT(1'b0)) u_sync_sdi (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.pin     (spi_sdi),
		.sync    (sdi_s)
	);

	assign cs_act = !cs_n_s;

	// =====================================================
	// Shifter
	scfg_link_if link ();
	scfg_main_t  st_r;
	scfg_main_t  st_nxt;

	scfg_shift u_shift (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.link    (link.shf)
	);

	assign link.active  = (st_r.fsm != SCFG_IDLE) && (st_r.rst_cnt == 5'h00);
	assign link.rise    = sclk_s && !st_r.sclk_q;
	assign link.fall    = !sclk_s && st_r.sclk_q;
	assign link.sdi     = sdi_s;
	assign link.tx_load = st_r.tx_load;
	assign link.tx_byte = st_r.tx_byte;
	assign spi_sdo      = link.sdo;

	// =====================================================
	// Read view
	function automatic logic [7:0] rd_byte(input logic [14:0] a);
		logic [7:0] v;
		v = UNMAPPED_VAL;
		case (a)
			OFS_CFG: begin
				v              = st_r.cfg;
				v[CFG_RST_BIT] = 1'b0;
				v[CFG_SDO_BIT] = 1'b1;
			end
			OFS_MODE: begin
				v = st_r.mode;
			end
			OFS_ID_LO: begin
				v = MAKER_ID[7:0];
			end
			OFS_ID_HI: begin
				v = MAKER_ID[15:8];
			end
			OFS_STREAM: begin
				v = st_r.stream;
			end
			default: begin
				v = UNMAPPED_VAL;
			end
		endcase
		return v;
	endfunction

	// =====================================================
	// Address stepping
	function automatic logic [14:0] step(
		input logic [14:0] a,
		input logic        asc,
		input logic        hold
	);
		logic [14:0] n;
		n = a;
		if (hold) begin
			n = a;
		end else if (asc) begin
			n = a + 15'h0001;
		end else begin
			n = a - 15'h0001;
		end
		return n;
	endfunction

	// =====================================================
	// Frame and register logic
	logic [14:0] next_addr;

	always_comb begin
		st_nxt         = st_r;
		st_nxt.tx_load = 1'b0;
		st_nxt.sclk_q  = sclk_s;
		st_nxt.cs_q    = cs_act;
		next_addr      = step(st_r.addr, st_r.asc, st_r.hold);
		if (st_r.rst_cnt != 5'h00) begin
			// Frames ignored while the chip resets
			st_nxt.rst_cnt = st_r.rst_cnt - 5'h01;
			st_nxt.fsm     = SCFG_IDLE;
		end else begin
			unique case (st_r.fsm)
				SCFG_IDLE: begin
					if (cs_act && !st_r.cs_q) begin
						st_nxt.fsm    = SCFG_HDR;
						st_nxt.hdr_hi = 1'b0;
					end
				end
				SCFG_HDR: begin
					if (!cs_act) begin
						st_nxt.fsm = SCFG_IDLE;
					end else if (link.byte_done && !st_r.hdr_hi) begin
						st_nxt.hdr_hi     = 1'b1;
						st_nxt.rd         = link.rx_byte[HDR_RD_BIT];
						st_nxt.addr[14:8] = link.rx_byte[6:0];
					end else if (link.byte_done) begin
						st_nxt.addr[7:0] = link.rx_byte;
						st_nxt.asc       = st_r.cfg[CFG_ASC_BIT];
						st_nxt.hold      = st_r.stream[STR_HOLD_BIT];
						st_nxt.fsm       = SCFG_DATA;
						if (st_r.rd) begin
							st_nxt.tx_load = 1'b1;
							st_nxt.tx_byte = rd_byte({st_r.addr[14:8], link.rx_byte});
						end
					end
				end
				SCFG_DATA: begin
					if (!cs_act) begin
						st_nxt.fsm = SCFG_IDLE;
					end else if (link.byte_done) begin
						st_nxt.addr = next_addr;
						if (st_r.rd) begin
							st_nxt.tx_load = 1'b1;
							st_nxt.tx_byte = rd_byte(next_addr);
						end else begin
							case (st_r.addr)
								OFS_CFG: begin
									if (link.rx_byte[CFG_RST_BIT]) begin
										// Whole bank back to reset values
										st_nxt.cfg     = CFG_RST;
										st_nxt.mode    = MODE_RST;
										st_nxt.stream  = STREAM_RST;
										st_nxt.asc     = 1'b1;
										st_nxt.hold    = 1'b0;
										st_nxt.rst_cnt = SOFT_RST_CYC;
										st_nxt.fsm     = SCFG_IDLE;
									end else begin
										st_nxt.cfg = link.rx_byte;
									end
								end
								OFS_MODE: begin
									st_nxt.mode = link.rx_byte;
								end
								OFS_STREAM: begin
									st_nxt.stream = link.rx_byte;
								end
								default: begin
									// Read-only and unmapped ignore writes
									st_nxt.fsm = SCFG_DATA;
								end
							endcase
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_r         <= '0;
			st_r.fsm     <= SCFG_IDLE;
			st_r.cs_q    <= 1'b0;
			st_r.asc     <= 1'b1;
			st_r.cfg     <= CFG_RST;
			st_r.mode    <= MODE_RST;
			st_r.stream  <= STREAM_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// =====================================================
	// Control outputs
	assign chip_reset      = (st_r.rst_cnt != 5'h00);
	assign power_mode      = st_r.mode[1:0];
	assign full_power_down = (st_r.mode[1:0] == MODE_PDN);
	assign addr_ascend     = st_r.cfg[CFG_ASC_BIT];
	assign addr_hold       = st_r.stream[STR_HOLD_BIT];
endmodule // scfg_bank

// ===== verilog/scfg_pkg.sv
/*
 Constants, field layout, reset values and types of the serial
 configuration register bank.
 Assumes a 20 MHz system clock and byte-wide register locations.
*/
package scfg_pkg;
	// =====================================================
	// Timing
	localparam int          SYS_CLK_MHZ  = 20;
	localparam int          SOFT_RST_NS  = 750;
	localparam logic [4:0]  SOFT_RST_CYC = 5'(SOFT_RST_NS * SYS_CLK_MHZ / 1000);

	// =====================================================
	// Register offsets
	localparam int          ADDR_W       = 15;
	localparam logic [14:0] OFS_CFG      = 15'h0000;
	localparam logic [14:0] OFS_MODE     = 15'h0002;
	localparam logic [14:0] OFS_ID_LO    = 15'h000c;
	localparam logic [14:0] OFS_ID_HI    = 15'h000d;
	localparam logic [14:0] OFS_STREAM   = 15'h0010;

	// =====================================================
	// Fields and reset values
	localparam int          CFG_RST_BIT  = 7;
	localparam int          CFG_ASC_BIT  = 5;
	localparam int          CFG_SDO_BIT  = 4;
	localparam int          STR_HOLD_BIT = 0;
	localparam int          HDR_RD_BIT   = 7;
	localparam logic [7:0]  CFG_RST      = 8'h30;
	localparam logic [7:0]  MODE_RST     = 8'h00;
	localparam logic [7:0]  STREAM_RST   = 8'h00;
	localparam logic [7:0]  UNMAPPED_VAL = 8'h00;
	localparam logic [1:0]  MODE_NORMAL  = 2'h0;
	localparam logic [1:0]  MODE_PDN     = 2'h3;

	// =====================================================
	// Types
	typedef enum logic [1:0] {
		SCFG_IDLE,
		SCFG_HDR,
		SCFG_DATA
	} scfg_fsm_t;

	typedef struct packed {
		scfg_fsm_t   fsm;
		logic        sclk_q;
		logic        cs_q;
		logic        hdr_hi;
		logic        rd;
		logic [14:0] addr;
		logic        asc;
		logic        hold;
		logic [7:0]  cfg;
		logic [7:0]  mode;
		logic [7:0]  stream;
		logic [4:0]  rst_cnt;
		logic        tx_load;
		logic [7:0]  tx_byte;
	} scfg_main_t;

	typedef struct packed {
		logic [2:0] bit_cnt;
		logic [7:0] rx_sh;
		logic [7:0] tx_sh;
		logic       sdo;
		logic       done;
		logic [7:0] rx_byte;
	} scfg_shift_t;

	typedef struct packed {
		logic s1;
		logic s2;
	} scfg_sync_t;
endpackage

// ===== verilog/scfg_link_if.sv
/*
 Internal link between the register bank and its bit shifter.
 Assumes both ends run on sys_clk.
*/
`timescale 1ns/1ps
interface scfg_link_if;
	logic       rise;
	logic       fall;
	logic       sdi;
	logic       active;
	logic       byte_done;
	logic [7:0] rx_byte;
	logic       tx_load;
	logic [7:0] tx_byte;
	logic       sdo;

	modport ctl (
		output rise,
		output fall,
		output sdi,
		output active,
		output tx_load,
		output tx_byte,
		input  byte_done,
		input  rx_byte,
		input  sdo
	);
	modport shf (
		input  rise,
		input  fall,
		input  sdi,
		input  active,
		input  tx_load,
		input  tx_byte,
		output byte_done,
		output rx_byte,
		output sdo
	);
endinterface

// ===== verilog/scfg_sync.sv
/*
 Two flip-flop synchroniser for one pin.
 Assumes the pin is asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module scfg_sync
	import scfg_pkg::*;
#(
	parameter logic INIT = 1'b0
) (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic pin,
	output logic      sync
);
	scfg_sync_t st_r;
	scfg_sync_t st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = pin;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '{s1: INIT, s2: INIT};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync = st_r.s2;
endmodule // scfg_sync

// ===== verilog/scfg_shift.sv
/*
 Byte shifter: samples data on clock rise, drives data on clock fall,
 most significant bit first.
 Assumes edge strobes already synchronised by the register bank.
*/
`timescale 1ns/1ps
module scfg_shift
	import scfg_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic nrst,
	scfg_link_if.shf  link
);
	scfg_shift_t st_r;
	scfg_shift_t st_nxt;

	always_comb begin
		st_nxt      = st_r;
		st_nxt.done = 1'b0;
		if (!link.active) begin
			st_nxt.bit_cnt = 3'h0;
			st_nxt.sdo     = 1'b0;
		end else begin
			if (link.rise) begin
				st_nxt.rx_sh   = {st_r.rx_sh[6:0], link.sdi};
				st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
				if (st_r.bit_cnt == 3'h7) begin
					st_nxt.done    = 1'b1;
					st_nxt.rx_byte = {st_r.rx_sh[6:0], link.sdi};
				end
			end
			// Load outranks shift
			if (link.tx_load) begin
				st_nxt.tx_sh = link.tx_byte;
			end else if (link.fall) begin
				st_nxt.sdo   = st_r.tx_sh[7];
				st_nxt.tx_sh = {st_r.tx_sh[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign link.byte_done = st_r.done;
	assign link.rx_byte   = st_r.rx_byte;
	assign link.sdo       = st_r.sdo;
endmodule // scfg_shift

// ===== dv/scfg_bank_props.sv
/*
 Checker of the register bank outputs against its serial pins.
 Assumes it is bound to scfg_bank and sees only its ports.
*/
`timescale 1ns/1ps
module scfg_bank_props (
	input wire logic       sys_clk,
	input wire logic       nrst,
	input wire logic       spi_sclk,
	input wire logic       spi_cs_n,
	input wire logic       spi_sdi,
	input wire logic       spi_sdo,
	input wire logic       chip_reset,
	input wire logic [1:0] power_mode,
	input wire logic       full_power_down,
	input wire logic       addr_ascend,
	input wire logic       addr_hold
);
	// =====================================================
	// Properties
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	chk_pdn_decode: assert property (full_power_down == (power_mode == 2'h3))
		else $error("power down flag disagrees with mode");
	chk_rst_len: assert property ($rose(chip_reset) |->
		chip_reset[*8] ##1 chip_reset[*7] ##1 !chip_reset)
		else $error("soft reset pulse length wrong");
	chk_rst_clears: assert property ($rose(chip_reset) |->
		##[1:15] (power_mode == 2'h0 && addr_ascend && !addr_hold))
		else $error("soft reset left registers set");
	chk_rst_cause: assert property ($rose(chip_reset) |-> !spi_cs_n)
		else $error("soft reset outside a frame");
	chk_cfg_framed: assert property (!$stable({power_mode, addr_ascend, addr_hold}) |->
		!spi_cs_n || !$past(spi_cs_n, 3) || chip_reset || $past(chip_reset))
		else $error("configuration changed outside a frame");
	chk_sdo_idle: assert property (spi_cs_n [*8] |-> !spi_sdo)
		else $error("data out active while deselected");
	chk_sdo_steady: assert property (spi_sclk && $past(spi_sclk) && !spi_cs_n |->
		$stable(spi_sdo))
		else $error("data out moved while clock high");
	chk_reset_vals: assert property ($rose(nrst) |->
		addr_ascend && !addr_hold && power_mode == 2'h0)
		else $error("outputs wrong after reset");
	cover property ($rose(chip_reset));
	cover property (full_power_down);
	cover property (addr_hold && !addr_ascend);
endmodule // scfg_bank_props

bind scfg_bank scfg_bank_props scfg_bank_props_i (
	.sys_clk(sys_clk), .nrst(nrst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
	.spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .chip_reset(chip_reset),
	.power_mode(power_mode), .full_power_down(full_power_down),
	.addr_ascend(addr_ascend), .addr_hold(addr_hold));

// ===== dv/scfg_host.sv
/*
 Serial host model: frames of header and data bytes.
 Assumes sys_clk for pacing; serial clock period is eight cycles.
*/
`timescale 1ns/1ps
module scfg_host (
	input  wire logic sys_clk,
	output logic      spi_sclk,
	output logic      spi_cs_n,
	output logic      spi_sdi,
	input  wire logic spi_sdo
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_sdi  = 1'b0;
	end
	// =====================================================
	// One frame, header then n data bytes
	task automatic frame(input logic [15:0] h, input int n, input logic [15:0] w,
		output logic [15:0] r);
		logic [31:0] v;
		v = {h, w};
		r = 16'h0000;
		@(negedge sys_clk);
		spi_cs_n = 1'b0;
		for (int i = 0; i < 16 + 8 * n; i++) begin
			spi_sdi = v[31 - i];
			repeat (4) @(negedge sys_clk);
			spi_sclk = 1'b1;
			repeat (2) @(negedge sys_clk);
			if (i >= 16) r = {r[14:0], spi_sdo};
			repeat (2) @(negedge sys_clk);
			spi_sclk = 1'b0;
		end
		repeat (4) @(negedge sys_clk);
		spi_cs_n = 1'b1;
		spi_sdi  = ~spi_sdi;
		repeat (4) @(negedge sys_clk);
	endtask
endmodule // scfg_host

// ===== dv/tb_top.sv
/*
 Self-checking bench: table of single accesses, then streams and soft reset.
 Assumes the host model paces every frame on sys_clk.
*/
`timescale 1ns/1ps
module tb_top;
	import scfg_pkg::*;
	localparam logic [15:0] MID = 16'ha5c3; // Arbitrary
	typedef struct packed {
		logic        wr;
		logic [14:0] a;
		logic [7:0]  d;
		logic [7:0]  e;
		logic [3:0]  o;
	} scfg_row_t;
	logic       sys_clk, nrst, spi_sclk, spi_cs_n, spi_sdi, spi_sdo;
	logic       chip_reset, full_power_down, addr_ascend, addr_hold, rst_seen;
	logic [1:0] power_mode;
	logic [15:0] r;
	int         miscompares, cmp_count;
	scfg_row_t  rows [12] = '{
		'{1'b0, 15'h0000, 8'h00, 8'h30, 4'h4}, '{1'b0, 15'h0002, 8'h00, 8'h00, 4'h4},
		'{1'b0, 15'h000c, 8'h00, MID[7:0], 4'h4}, '{1'b0, 15'h000d, 8'h00, MID[15:8], 4'h4},
		'{1'b1, 15'h000c, 8'hff, MID[7:0], 4'h4}, '{1'b1, 15'h0000, 8'h10, 8'h10, 4'h0},
		'{1'b1, 15'h0000, 8'h30, 8'h30, 4'h4}, '{1'b1, 15'h0002, 8'h03, 8'h03, 4'h7},
		'{1'b1, 15'h0002, 8'h00, 8'h00, 4'h4}, '{1'b1, 15'h0010, 8'h01, 8'h01, 4'hc},
		'{1'b1, 15'h0010, 8'h00, 8'h00, 4'h4}, '{1'b0, 15'h0020, 8'h00, 8'h00, 4'h4}};

	scfg_bank #(.MAKER_ID(MID)) scfg_bank_i (.sys_clk(sys_clk), .nrst(nrst),
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
		.chip_reset(chip_reset), .power_mode(power_mode),
		.full_power_down(full_power_down), .addr_ascend(addr_ascend), .addr_hold(addr_hold));
	scfg_host scfg_host_i (.sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out;
		if (miscompares == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// =====================================================
	// Clock, pulse monitor, watchdog
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (chip_reset === 1'b1) rst_seen <= 1'b1;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		close_out();
	end
	// =====================================================
	// Sequence
	initial begin
		nrst = 1'b0;
		rst_seen = 1'b0;
		miscompares = 0;
		cmp_count = 0;
		repeat (10) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (4) @(negedge sys_clk);
		foreach (rows[k]) begin
			if (rows[k].wr) scfg_host_i.frame({1'b0, rows[k].a}, 1, {rows[k].d, 8'h00}, r);
			scfg_host_i.frame({1'b1, rows[k].a}, 1, 16'h0000, r);
			chk("data", {8'h00, r[7:0]}, {8'h00, rows[k].e});
			chk("outs", {12'h000, addr_hold, addr_ascend, power_mode}, {12'h000, rows[k].o});
			chk("pdn", {15'h0000, full_power_down}, {15'h0000, rows[k].o[1:0] == 2'h3});
		end
		scfg_host_i.frame(16'h800c, 2, 16'h0000, r);
		chk("stream up", r, {MID[7:0], MID[15:8]});
		scfg_host_i.frame(16'h0000, 1, 16'h1000, r);
		scfg_host_i.frame(16'h800d, 2, 16'h0000, r);
		chk("stream down", r, MID);
		scfg_host_i.frame(16'h0010, 1, 16'h0100, r);
		scfg_host_i.frame(16'h800c, 2, 16'h0000, r);
		chk("stream hold", r, {MID[7:0], MID[7:0]});
		scfg_host_i.frame(16'h0002, 1, 16'h0300, r);
		scfg_host_i.frame(16'h0000, 1, 16'h9000, r);
		repeat (16) @(negedge sys_clk);
		chk("soft reset", {12'h000, addr_hold, addr_ascend, power_mode}, 16'h0004);
		chk("pulse", {15'h0000, rst_seen}, 16'h0001);
		scfg_host_i.frame(16'h8000, 1, 16'h0000, r);
		chk("cfg after", r, 16'h0030);
		close_out();
	end
endmodule // tb_top
